/* File: rtl/qsp_device_end.sv */
`timescale 1ns/100ps
// Behaviour
// RULE_01: write words taken on K and K-bar rises
// RULE_02: low write select at K starts write
// RULE_03: deselected write port ignores data inputs
// RULE_04: narrow variant: two nibble masks, low/high nibble
// RULE_05: masked nibble keeps its stored value
// RULE_06: wide variants: byte masks gate 9-bit lanes
// RULE_07: masked lane keeps its stored value
// RULE_08: masks sampled with their own data word
// RULE_09: read address at K, write at K-bar
// RULE_10: address width 22, 21 or 20 bits
// RULE_11: two equal halves, one word each
// RULE_12: deselected port ignores its address edge
// RULE_13: read data launched on C pair edges (in single clock mode the code launches on K and K-bar)
// RULE_14: deselected read port tristates outputs itself
// RULE_15: low read select at K starts read
// RULE_16: pending read finishes, then outputs tristate
// RULE_17: every read bursts two words
// RULE_18: every access begins on K rise
// RULE_19: PLL off gives one-cycle read latency
// RULE_20: free-running echo clock follows output clock
module qsp_device_end
	import qsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	qsp_link_if.device link,
	output logic wr_done,
	output logic [ADDR_W-1:0] wr_done_addr,
	output logic rd_start,
	output logic pll_off
);

	typedef struct packed {
		// first half of a write, held until its K-bar edge
		logic wr_pend;
		logic [DATA_W-1:0] wd0;
		logic [LANES-1:0] wm0_n;

		// read pipe, one stage per output edge
		logic [RD_PIPE-1:0] sh;
		logic [RD_PIPE-1:0][ADDR_W-1:0] sh_addr;

		// output register and echo level
		logic [DATA_W-1:0] q;
		logic q_oe_n;
		logic echo;

		// user side pulses
		logic wr_done;
		logic [ADDR_W-1:0] wr_done_addr;
		logic rd_start;
	} qsp_dev_t;
	qsp_dev_t st, next_st;

	logic out_rise;
	logic out_fall;
	logic out_edge;

	logic rd_take;
	logic wr_take;
	logic wr_commit;

	// read word lookup, one stage ahead of the output register
	logic [1:0] idx0;
	logic [1:0] idx1;
	logic [ADDR_W-1:0] raddr0; // see RULE_10
	logic [ADDR_W-1:0] raddr1;

	logic [DATA_W-1:0] rword0;
	logic [DATA_W-1:0] rword1;

	// ====================================================
	// edge decode
	// C pair times the outputs unless single clock mode
	always_comb begin
		if (link.single_clock_mode) begin
			out_rise = link.k_rise; // see RULE_18
			out_fall = link.kn_rise;
		end else begin
			out_rise = link.c_rise;
			out_fall = link.cn_rise;
		end

		out_edge = out_rise || out_fall; // see RULE_13

		rd_take = link.k_rise && !link.read_port_select_n; // see RULE_15
		wr_take = link.k_rise && !link.write_port_select_n; // see RULE_02

		// second half of the write needs the K-bar edge after the command
		wr_commit = link.kn_rise && st.wr_pend;
	end

	// pll on: words at 3 and 4 edges after the command, off: 2 and 3
	assign idx0 = link.pll_disable_n ? 2'(LAT_PLL_ON - 2) :
		2'(LAT_PLL_OFF - 2); // see RULE_19
	assign idx1 = idx0 + 2'h1;

	assign raddr0 = st.sh_addr[idx0];
	assign raddr1 = st.sh_addr[idx1];

	// ====================================================
	// storage: one array per half and per lane
	// lane width comes from the package, so the 4-bit nibble
	// variant is the same loop with two lanes
	genvar gl;

	generate
		for (gl = 0; gl < LANES; gl++) begin : g_lane
			logic [LANE_W-1:0] half_lo [WORDS];
			logic [LANE_W-1:0] half_hi [WORDS];

			always_ff @(posedge clk_sys) begin
				if (wr_commit) begin
					// masked lane is skipped, old contents stay
					if (!st.wm0_n[gl]) begin // see RULE_04 RULE_06
						half_lo[link.addr] <= st.wd0[gl*LANE_W +: LANE_W]; // see RULE_05 RULE_07
					end
					if (!link.byte_lane_write_mask_n[gl]) begin // see RULE_08
						half_hi[link.addr] <= link.d[gl*LANE_W +: LANE_W]; // see RULE_11
					end
				end
			end

			// read and commit to one address in one cycle return the old word
			assign rword0[gl*LANE_W +: LANE_W] = half_lo[raddr0];
			assign rword1[gl*LANE_W +: LANE_W] = half_hi[raddr1];
		end
	endgenerate

	// ====================================================
	// control
	always_comb begin
		next_st = st;
		next_st.wr_done = 1'b0;
		next_st.rd_start = rd_take;

		// write select sampled only at K; data ignored otherwise
		if (wr_take) begin
			next_st.wr_pend = 1'b1;
			next_st.wd0 = link.d; // see RULE_01
			next_st.wm0_n = link.byte_lane_write_mask_n; // see RULE_08
		end else if (wr_commit) begin
			next_st.wr_pend = 1'b0;
		end else if (link.k_rise) begin
			next_st.wr_pend = 1'b0; // see RULE_03
		end

		if (wr_commit) begin
			// address bus taken at K-bar only for a pending write
			next_st.wr_done = 1'b1; // see RULE_09 RULE_12
			next_st.wr_done_addr = link.addr;
		end

		// read pipe shifts on each output edge; the C pair must run outside single clock mode
		if (out_edge) begin
			next_st.sh = {st.sh[RD_PIPE-2:0], rd_take}; // see RULE_17
			next_st.sh_addr = {st.sh_addr[RD_PIPE-2:0],
				rd_take ? link.addr : ADDR_ZERO}; // see RULE_12

			// word0 then word1, one per output edge
			if (st.sh[idx0]) begin
				next_st.q = rword0;
				next_st.q_oe_n = 1'b0;
			end else if (st.sh[idx1]) begin
				next_st.q = rword1; // see RULE_17
				next_st.q_oe_n = 1'b0;
			end else begin
				// burst done or read port idle: release the bus
				next_st.q_oe_n = 1'b1; // see RULE_14 RULE_16
			end
		end else if (rd_take) begin
			next_st.sh[0] = 1'b1;
			next_st.sh_addr[0] = link.addr;
		end

		// echo runs whether or not a read is in flight
		if (out_rise) begin
			next_st.echo = 1'b1; // see RULE_20
		end else if (out_fall) begin
			next_st.echo = 1'b0;
		end
	end

	// memories stay out of reset; only control state clears
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.wm0_n <= MASK_IDLE;
			st.q_oe_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ====================================================
	// outputs
	assign link.q = st.q;
	assign link.q_oe_n = st.q_oe_n;
	assign link.echo_clock = st.echo;
	assign link.echo_clock_n = !st.echo;

	assign wr_done = st.wr_done;
	assign wr_done_addr = st.wr_done_addr;
	assign rd_start = st.rd_start;

	// pll state is a pin level, no register needed
	assign pll_off = !link.pll_disable_n;
endmodule

/* File: rtl/qsp_pkg.sv */
package qsp_pkg;
	// ====================================================
	// widths of the widest variant, 36-bit words, 9-bit lanes
	localparam int DATA_W = 36;
	localparam int LANE_W = 9;
	localparam int LANES = 4;
	localparam int ADDR_W = 20;
	localparam int WORDS = 1 << ADDR_W;
	// ====================================================
	// timing, one K or K-bar edge per clk_sys cycle
	localparam int CLK_PERIOD_NS = 100;
	localparam int K_PERIOD_NS = 200;
	localparam int K_PERIOD_CYC = K_PERIOD_NS / CLK_PERIOD_NS;
	localparam int LAT_PLL_ON = 3;
	localparam int LAT_PLL_OFF = 2;
	localparam int RD_PIPE = 3;
	localparam int RSP_PIPE = 5;
	// ====================================================
	// request queue
	localparam int FIFO_DEPTH = 16;
	localparam int WREQ_W = ADDR_W + 2 * DATA_W + 2 * LANES;
	// ====================================================
	// reset values
	localparam logic [LANES-1:0] MASK_IDLE = 4'hF;
	localparam logic [DATA_W-1:0] DATA_ZERO = 36'h0;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h0;
endpackage

/* File: rtl/qsp_link_if.sv */
`timescale 1ns/100ps
interface qsp_link_if;
	import qsp_pkg::*;
	logic k_rise;
	logic kn_rise;
	logic c_rise;
	logic cn_rise;
	logic single_clock_mode;
	logic pll_disable_n;
	logic read_port_select_n;
	logic write_port_select_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] d;
	logic [LANES-1:0] byte_lane_write_mask_n;
	logic [DATA_W-1:0] q;
	logic q_oe_n;
	logic echo_clock;
	logic echo_clock_n;
	modport device(
		input k_rise, kn_rise, c_rise, cn_rise, single_clock_mode, pll_disable_n,
		input read_port_select_n, write_port_select_n, addr, d, byte_lane_write_mask_n,
		output q, q_oe_n, echo_clock, echo_clock_n
	);
	modport host(
		output k_rise, kn_rise, c_rise, cn_rise, single_clock_mode, pll_disable_n,
		output read_port_select_n, write_port_select_n, addr, d, byte_lane_write_mask_n,
		input q, q_oe_n, echo_clock, echo_clock_n
	);
endinterface

/* File: rtl/qsp_fifo.sv */
`timescale 1ns/100ps
module qsp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} qsp_fifo_t;
	qsp_fifo_t st, next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;
	assign in_ready = st.cnt != (AW+1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = mem[st.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.wr = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[st.wr] <= in_data;
		end
	end
endmodule

/* File: rtl/qsp_host_end.sv */
`timescale 1ns/100ps
module qsp_host_end
	import qsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	qsp_link_if.host link,
	input wire logic cfg_single_clock,
	input wire logic cfg_pll_disable_n,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [DATA_W-1:0] wr_data0,
	input wire logic [DATA_W-1:0] wr_data1,
	input wire logic [LANES-1:0] wr_mask0_n,
	input wire logic [LANES-1:0] wr_mask1_n,
	input wire logic rd_valid,
	output logic rd_ready,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_data0,
	output logic [DATA_W-1:0] rsp_data1
);
	typedef struct packed {
		logic phase;
		logic rps_n;
		logic wps_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] d;
		logic [LANES-1:0] mask_n;
		logic wr_hold;
		logic [ADDR_W-1:0] hold_addr;
		logic [DATA_W-1:0] hold_d;
		logic [LANES-1:0] hold_mask_n;
		logic [RSP_PIPE-1:0] rd_sh;
		logic rsp_valid;
		logic [DATA_W-1:0] rsp0;
		logic [DATA_W-1:0] rsp1;
	} qsp_host_t;
	qsp_host_t st, next_st;
	logic q_valid;
	logic q_ready;
	logic [WREQ_W-1:0] q_data;
	logic [2:0] lat;
	// ====================================================
	// write queue; drains only once per K period
	qsp_fifo #(
		.WIDTH(WREQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_wq (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.in_valid(wr_valid),
		.in_ready(wr_ready),
		.in_data({wr_addr, wr_data0, wr_data1, wr_mask0_n, wr_mask1_n}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);
	assign q_ready = st.phase;
	assign rd_ready = st.phase;
	assign lat = cfg_pll_disable_n ? 3'(LAT_PLL_ON) : 3'(LAT_PLL_OFF);
	// ====================================================
	// link drive
	assign link.k_rise = !st.phase;
	assign link.kn_rise = st.phase;
	assign link.c_rise = !st.phase;
	assign link.cn_rise = st.phase;
	assign link.single_clock_mode = cfg_single_clock;
	assign link.pll_disable_n = cfg_pll_disable_n;
	assign link.read_port_select_n = st.rps_n;
	assign link.write_port_select_n = st.wps_n;
	assign link.addr = st.addr;
	assign link.d = st.d;
	assign link.byte_lane_write_mask_n = st.mask_n;
	assign rsp_valid = st.rsp_valid;
	assign rsp_data0 = st.rsp0;
	assign rsp_data1 = st.rsp1;
	always_comb begin
		next_st = st;
		next_st.phase = !st.phase;
		next_st.rsp_valid = 1'b0;
		next_st.rd_sh = {st.rd_sh[RSP_PIPE-2:0], !st.phase && !st.rps_n};
		if (st.phase) begin
			// next cycle is a K rise: commands, read address, first word
			next_st.rps_n = !rd_valid; // see RULE_15
			next_st.addr = rd_valid ? rd_addr : st.addr; // see RULE_09
			next_st.wps_n = !q_valid; // see RULE_02
			next_st.mask_n = MASK_IDLE;
			next_st.wr_hold = q_valid;
			if (q_valid) begin
				next_st.d = q_data[WREQ_W-ADDR_W-1 -: DATA_W];
				next_st.mask_n = q_data[2*LANES-1 -: LANES]; // see RULE_08
				next_st.hold_addr = q_data[WREQ_W-1 -: ADDR_W];
				next_st.hold_d = q_data[2*LANES +: DATA_W];
				next_st.hold_mask_n = q_data[LANES-1:0];
			end
		end else begin
			// next cycle is a K-bar rise: write address, second word
			next_st.rps_n = 1'b1;
			next_st.wps_n = 1'b1;
			next_st.mask_n = st.wr_hold ? st.hold_mask_n : MASK_IDLE; // see RULE_08
			if (st.wr_hold) begin
				next_st.addr = st.hold_addr; // see RULE_09
				next_st.d = st.hold_d;
			end
		end
		// words arrive lat and lat+1 cycles after the K rise of the read
		if (st.rd_sh[lat-3'd1]) begin
			next_st.rsp0 = link.q;
		end
		if (st.rd_sh[lat]) begin
			next_st.rsp1 = link.q; // see RULE_17
			next_st.rsp_valid = 1'b1;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.rps_n <= 1'b1;
			st.wps_n <= 1'b1;
			st.mask_n <= MASK_IDLE;
			st.hold_mask_n <= MASK_IDLE;
		end else begin
			st <= next_st;
		end
	end
endmodule

/* File: testbench/qsp_link_monitor.sv */
`timescale 1ns/100ps
// ==============================
// link checker
module qsp_link_monitor (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic k_rise,
	input wire logic kn_rise,
	input wire logic c_rise,
	input wire logic cn_rise,
	input wire logic pll_disable_n,
	input wire logic read_port_select_n,
	input wire logic q_oe_n,
	input wire logic echo_clock,
	input wire logic echo_clock_n
);
	logic rd_cmd;
	assign rd_cmd = k_rise & ~read_port_select_n;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_rd_cmd;
		rd_cmd;
	endsequence
	sequence s_two_words;
		!q_oe_n ##1 !q_oe_n;
	endsequence
	a_kn_twin: assert property (kn_rise == !k_rise)
		else $error("kn_rise is not the inverse of k_rise");
	a_k_alternate: assert property ($past(reset_n) |-> k_rise != $past(k_rise))
		else $error("k_rise did not alternate");
	a_c_phase: assert property ($past(reset_n) |->
		c_rise == k_rise && cn_rise == kn_rise)
		else $error("output clock enables out of phase");
	a_rd_lat_on: assert property (s_rd_cmd ##0 pll_disable_n |-> ##3 s_two_words)
		else $error("read burst late with pll on");
	a_rd_lat_off: assert property (s_rd_cmd ##0 !pll_disable_n |-> ##2 s_two_words)
		else $error("read burst late with pll off");
	a_rd_tristate: assert property (!q_oe_n |-> (pll_disable_n ?
		($past(rd_cmd, 3) || $past(rd_cmd, 4)) : ($past(rd_cmd, 2) || $past(rd_cmd, 3))))
		else $error("read data driven without a read");
	a_burst_two: assert property ($fell(q_oe_n) |-> ##1 !q_oe_n)
		else $error("read burst shorter than two words");
	a_echo_runs: assert property ($past(reset_n, 2) |->
		echo_clock != $past(echo_clock))
		else $error("echo clock stopped");
	a_echo_pair: assert property ($past(reset_n, 2) |-> echo_clock_n == !echo_clock)
		else $error("echo clock pair not inverse");
endmodule

/* File: testbench/test_quad_rate_sram_port_interface.sv */
`timescale 1ns/100ps
module test_quad_rate_sram_port_interface;
	import qsp_pkg::*;
	logic clk_sys, reset_n, cfg_single_clock, cfg_pll_disable_n, wr_valid, wr_ready;
	logic rd_valid, rd_ready, rsp_valid, wr_done, rd_start, pll_off, saw_full;
	logic [ADDR_W-1:0] wr_addr, rd_addr, wr_done_addr;
	logic [DATA_W-1:0] wr_data0, wr_data1, rsp_data0, rsp_data1;
	logic [LANES-1:0] wr_mask0_n, wr_mask1_n;
	logic [2*DATA_W-1:0] mem [4];
	logic [ADDR_W-1:0] at [4];
	logic [2*DATA_W-1:0] rexp [$];
	logic [ADDR_W-1:0] wexp [$];
	int error_cnt, cmp_count, rd_cnt, starts;
	qsp_link_if u_qsp_link_if ();
	qsp_host_end u_qsp_host_end (.clk_sys(clk_sys), .reset_n(reset_n), .link(u_qsp_link_if.host),
		.cfg_single_clock(cfg_single_clock), .cfg_pll_disable_n(cfg_pll_disable_n),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data0(wr_data0),
		.wr_data1(wr_data1), .wr_mask0_n(wr_mask0_n), .wr_mask1_n(wr_mask1_n),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_addr(rd_addr), .rsp_valid(rsp_valid),
		.rsp_data0(rsp_data0), .rsp_data1(rsp_data1));
	qsp_device_end u_qsp_device_end (.clk_sys(clk_sys), .reset_n(reset_n),
		.link(u_qsp_link_if.device), .wr_done(wr_done), .wr_done_addr(wr_done_addr),
		.rd_start(rd_start), .pll_off(pll_off));
	qsp_link_monitor u_qsp_link_monitor (.clk_sys(clk_sys), .reset_n(reset_n),
		.k_rise(u_qsp_link_if.k_rise), .kn_rise(u_qsp_link_if.kn_rise),
		.c_rise(u_qsp_link_if.c_rise), .cn_rise(u_qsp_link_if.cn_rise),
		.pll_disable_n(u_qsp_link_if.pll_disable_n),
		.read_port_select_n(u_qsp_link_if.read_port_select_n), .q_oe_n(u_qsp_link_if.q_oe_n),
		.echo_clock(u_qsp_link_if.echo_clock), .echo_clock_n(u_qsp_link_if.echo_clock_n));
	// ==============================
	// helpers
	task automatic test_done();
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [2*DATA_W-1:0] got, input logic [2*DATA_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ready judged at the falling edge, where the combinational ready has settled
	task automatic hs(input bit rd);
		logic ok;
		do begin
			@(negedge clk_sys);
			ok = rd ? rd_ready : wr_ready;
			if (!rd && ok !== 1'b1) saw_full = 1'b1;
			@(posedge clk_sys);
		end while (ok !== 1'b1);
		#10;
	endtask
	// lanes 0..3 are the first word, 4..7 the second
	function automatic logic [2*DATA_W-1:0] merge(input logic [2*DATA_W-1:0] old,
		input logic [2*DATA_W-1:0] nw, input logic [2*LANES-1:0] m);
		logic [2*DATA_W-1:0] r;
		r = old;
		for (int i = 0; i < 2 * LANES; i++) begin
			if (!m[i]) r[i*LANE_W +: LANE_W] = nw[i*LANE_W +: LANE_W];
		end
		return r;
	endfunction
	// ==============================
	// one pass: writes fill the queue, then reads back
	task automatic phase(input bit first);
		int k;
		for (int i = 0; i < 40; i++) begin
			k = (first && i < 4) ? i : $urandom_range(3);
			wr_valid = 1'b1;
			wr_addr = at[k];
			{wr_data1, wr_data0} = 72'({$urandom(), $urandom(), $urandom()});
			{wr_mask1_n, wr_mask0_n} = (first && i < 4) ? 8'h00 : 8'($urandom());
			hs(1'b0);
			mem[k] = merge(mem[k], {wr_data1, wr_data0}, {wr_mask1_n, wr_mask0_n});
			wexp.push_back(at[k]);
		end
		wr_valid = 1'b0;
		for (int i = 0; i < 400 && wexp.size() != 0; i++) @(posedge clk_sys);
		#10;
		for (int i = 0; i < 8; i++) begin
			k = (i < 4) ? i : $urandom_range(3);
			rd_valid = 1'b1;
			rd_addr = at[k];
			hs(1'b1);
			rexp.push_back(mem[k]);
			rd_cnt++;
		end
		rd_valid = 1'b0;
		for (int i = 0; i < 400 && rexp.size() != 0; i++) @(posedge clk_sys);
		#10;
		chk(72'(saw_full), 72'h1);
		chk(72'(starts), 72'(rd_cnt));
		chk(72'(pll_off), 72'(!cfg_pll_disable_n));
		saw_full = 1'b0;
	endtask
	always @(negedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			chk({rsp_data1, rsp_data0},
				rexp.size() ? rexp.pop_front() : 'x);
		end
		if (wr_done === 1'b1) begin
			chk(72'(wr_done_addr),
				72'(wexp.size() ? wexp.pop_front() : 'x));
		end
		if (rd_start === 1'b1) starts++;
	end
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		test_done();
	end
	initial begin
		void'($urandom(41651));
		at = '{ADDR_ZERO, 20'hFFFFF, 20'h5A5A5, 20'h00001};
		reset_n = 1'b0;
		cfg_single_clock = 1'b0;
		cfg_pll_disable_n = 1'b1;
		wr_valid = 1'b0;
		rd_valid = 1'b0;
		wr_addr = ADDR_ZERO;
		rd_addr = ADDR_ZERO;
		wr_data0 = DATA_ZERO;
		wr_data1 = DATA_ZERO;
		wr_mask0_n = MASK_IDLE;
		wr_mask1_n = MASK_IDLE;
		saw_full = 1'b0;
		repeat (10) @(posedge clk_sys);
		#10 reset_n = 1'b1;
		phase(1'b1);
		// second reset: contents survive, pll off and single clock from here on
		reset_n = 1'b0;
		cfg_pll_disable_n = 1'b0;
		cfg_single_clock = 1'b1;
		repeat (3) @(posedge clk_sys);
		#10 reset_n = 1'b1;
		phase(1'b0);
		test_done();
	end
endmodule
